// ---- bench/sps_flash_model.sv ----
// behavioural serial flash at the far side of the link
`timescale 1ns/1ps
module sps_flash_model
(
  input  wire logic       pclk,
  input  wire logic       link_clk,
  input  wire logic       flash_cs_n,
  input  wire logic [3:0] flash_io_out,
  input  wire logic [3:0] flash_io_oe,
  output logic      [3:0] flash_io_in,
  output logic      [7:0] cap_byte,
  output int              cap_bits
);
  logic [7:0] resp;
  logic [3:0] drv;
  logic       armed;
  initial
  begin
    resp = 8'h96;
    drv = 4'h0;
    armed = 1'b0;
    cap_byte = 8'h0;
    cap_bits = 0;
  end
  // driven lanes follow the controller, released ones show the model
  assign flash_io_in = (flash_io_oe & flash_io_out) | (~flash_io_oe & drv);
  always @(negedge flash_cs_n)
  begin
    cap_bits = 0;
    armed = 1'b0;
  end
  // reply msb first on lane 1, paired with the bit the controller clocks next;
  // a fall launches a bit only if the controller is already busy when it sees it
  always @(negedge link_clk)
    if (!flash_cs_n)
    begin
      drv = {2'h0, resp[3'(7 - cap_bits % 8)], 1'b0};
      #60;
      armed = flash_io_oe[0];
    end
  // deselected: lines toggle so a stale value never looks valid
  always @(posedge pclk)
    if (flash_cs_n)
      drv = ~drv;
  always @(posedge link_clk)
  begin
    if (!flash_cs_n && armed && flash_io_oe[0])
    begin
      cap_byte = {cap_byte[6:0], flash_io_out[0]};
      cap_bits++;
    end
    armed = 1'b0;
  end
endmodule : sps_flash_model

// ---- bench/sps_sequencer_asserts.sv ----
// checker: port-level properties of the phase sequencer
`timescale 1ns/1ps
module sps_sequencer_asserts
  import sps_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        flash_cs_n,
  input wire logic [3:0]  flash_io_oe,
  input wire logic        rx_valid,
  input wire logic        dma_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy_lat;
    psel && penable && !pready && ce |=> pready;
  endproperty
  a_rdy_lat: assert property (p_rdy_lat) else $error("pready late");
  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held");
  property p_err_rdy;
    pslverr |-> pready && (pwrite || prdata == 32'h0);
  endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("bad unmapped answer");
  property p_idle;
    flash_cs_n |-> flash_io_oe == 4'h0 && !rx_valid && !dma_req;
  endproperty
  a_idle: assert property (p_idle) else $error("link busy while idle");
  property p_oe;
    !flash_cs_n && flash_io_oe != 4'h0 |-> flash_io_oe inside {4'h1, 4'h3, 4'hf};
  endproperty
  a_oe: assert property (p_oe) else $error("bad lane enable");
  property p_go;
    psel && penable && pready && pwrite && paddr == OFF_XFER_CTRL && pwdata[0] && flash_cs_n
      |-> ##[1:3] !flash_cs_n;
  endproperty
  a_go: assert property (p_go) else $error("start not seen");
  property p_rx;
    rx_valid |=> !rx_valid;
  endproperty
  a_rx: assert property (p_rx) else $error("rx_valid held");
  property p_dma;
    dma_req |=> !dma_req;
  endproperty
  a_dma: assert property (p_dma) else $error("dma_req held");
  c_rx: cover property (rx_valid);
  c_dma: cover property (dma_req);
  c_err: cover property (pslverr);
  c_quad: cover property (!flash_cs_n && flash_io_oe == 4'hf);
endmodule : sps_sequencer_asserts

bind sps_sequencer sps_sequencer_asserts u_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .flash_cs_n(flash_cs_n), .flash_io_oe(flash_io_oe), .rx_valid(rx_valid),
  .dma_req(dma_req));

// ---- bench/testbench.sv ----
// self-checking bench of the phase sequencer
`timescale 1ns/1ps
module testbench;
  import sps_pkg::*;
  logic        pclk, presetn, ce, psel, penable, pwrite, link_clk, poll_pass, poll_fail, dma_ack, slv;
  logic        pready, pslverr, irq, flash_cs_n, rx_valid, dma_req;
  logic [7:0]  paddr, tx_byte, rx_byte, cap_byte, last_rx;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  flash_io_in, flash_io_out, flash_io_oe;
  logic [1:0]  tx_byte_index;
  int          cap_bits, errors, cmp_count, dma_seen, dma_wait, dma_gone;

  sps_sequencer #(.SLOTS(8)) DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .link_clk(link_clk), .flash_cs_n(flash_cs_n), .flash_io_in(flash_io_in),
    .flash_io_out(flash_io_out), .flash_io_oe(flash_io_oe), .tx_byte_index(tx_byte_index),
    .tx_byte(tx_byte), .rx_byte(rx_byte), .rx_valid(rx_valid), .poll_pass(poll_pass),
    .poll_fail(poll_fail), .dma_req(dma_req), .dma_ack(dma_ack));
  sps_flash_model u_flash (.pclk(pclk), .link_clk(link_clk), .flash_cs_n(flash_cs_n),
    .flash_io_out(flash_io_out), .flash_io_oe(flash_io_oe), .flash_io_in(flash_io_in),
    .cap_byte(cap_byte), .cap_bits(cap_bits));

  // ---------------------------------------------------------------
  // clocks, dma responder, watchdog
  // ---------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // link clock only runs inside a frame
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #160 link_clk = flash_cs_n ? 1'b0 : ~link_clk;
  end
  // slow dma service: one ack 41 cycles apart for every request, requests queue up
  always @(posedge pclk)
  begin
    dma_ack <= (dma_wait == 1);
    dma_seen <= dma_seen + (dma_req === 1'b1);
    dma_gone <= dma_gone + (dma_wait == 1);
    dma_wait <= (dma_wait != 0) ? dma_wait - 1 : ((dma_seen != dma_gone || dma_req === 1'b1) ? 40 : 0);
    if (rx_valid === 1'b1)
      last_rx <= rx_byte;
  end
  initial
  begin
    #(40 * 40000);
    errors++;
    print_verdict();
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50)
      errors++;
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_done();
    int n;
    rd = 32'h0;
    while (rd[XC_DONE_BIT] !== 1'b1 && n < 3000)
    begin
      apb(1'b0, OFF_XFER_CTRL, 32'h0);
      n++;
    end
    if (n >= 3000)
      errors++;
    chk(dma_wait, 0);
  endtask : wait_done

  task automatic run(input logic [31:0] ctrl);
    apb(1'b1, OFF_XFER_CTRL, ctrl); // slots are all written before go
    wait_done();
  endtask : run

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic s_regs();
    apb(1'b0, OFF_XFER_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OFF_SLOT_LAST, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk(slv, 1'b1);
    apb(1'b1, 8'h14, 32'hff10_0317);
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0010_0310);
    apb(1'b1, 8'h14, 32'h0030_0520);
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0010_0520);
    apb(1'b1, OFF_IRQ_MASK, 32'h1);
  endtask : s_regs

  task automatic s_tx();
    apb(1'b1, OFF_SLOT_BASE, 32'h0000_0200);
    run(32'h1);
    chk(rd[6:0], 7'h04);
    chk(cap_bits, 16);
    chk(cap_byte, 8'hc3);
    apb(1'b0, OFF_SLOT_BASE, 32'h0);
    chk(rd, 32'h0000_0202);
    chk(tx_byte_index, 2'h1);
    chk(irq, 1'b1);
    apb(1'b1, OFF_IRQ_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
  endtask : s_tx

  task automatic s_multi();
    apb(1'b1, 8'h14, 32'h0000_0110);
    apb(1'b1, 8'h18, 32'h0000_0120);
    apb(1'b1, 8'h1c, 32'h0000_0100);
    run(32'h21);
    chk(last_rx, 8'h96);
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b0, OFF_SLOT_BASE + 8'(4 * k), 32'h0);
      chk(rd[SL_DONE_BIT], k < 3);
    end
  endtask : s_multi

  task automatic s_poll();
    poll_fail <= 1'b1;
    apb(1'b1, OFF_SLOT_BASE, 32'h0010_0030);
    run(32'h1);
    chk(rd[3:2], 2'h3);
    poll_fail <= 1'b0;
    apb(1'b0, 8'h14, 32'h0);
    chk(rd[SL_DONE_BIT], 1'b0);
    apb(1'b1, OFF_IRQ_STAT, 32'h1);
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    chk(rd[1:0], 2'h2);
    chk(irq, 1'b0);
    apb(1'b1, OFF_XFER_CTRL, 32'h8);
    apb(1'b0, OFF_XFER_CTRL, 32'h0);
    chk(rd[3:2], 2'h2);
  endtask : s_poll

  task automatic s_dma();
    apb(1'b1, OFF_SLOT_BASE, 32'h0020_0500);
    run(32'h1);
    chk(rd[3:2], 2'h1);
    chk(dma_seen, 2);
  endtask : s_dma

  task automatic print_verdict();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  initial
  begin
    {presetn, psel, penable, pwrite, poll_pass, poll_fail} = '0;
    ce = 1'b1;
    paddr = 8'h0;
    pwdata = 32'h0;
    tx_byte = 8'hc3;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    s_tx();
    s_multi();
    s_poll();
    s_dma();
    print_verdict();
  end
endmodule : testbench

// ---- verilog/sps_lane_shifter.sv ----
// one-byte serialiser over one, two or four lanes, paced by link clock edges
`timescale 1ns/1ps
module sps_lane_shifter
  import sps_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            ce,
  input  wire logic            start,
  input  wire logic [7:0]      tx_byte,
  input  wire sps_pkg::sps_lane_t lanes,
  input  wire logic            drive,
  input  wire logic            link_rise,
  input  wire logic            link_fall,
  input  wire logic [3:0]      io_in,
  output logic      [3:0]      io_out,
  output logic      [3:0]      io_oe,
  output logic      [7:0]      rx_byte,
  output logic                 done
);

  logic [7:0] sr_reg;
  logic [3:0] steps_reg;
  logic       busy_reg;
  logic       armed_reg;
  logic [7:0] sr_next;
  logic [3:0] top_bits;

  always_comb
  begin
    case (lanes)
      LANE_DUAL:
      begin
        sr_next  = {sr_reg[5:0], io_in[1:0]};
        top_bits = {2'b00, sr_reg[7:6]};
      end
      LANE_QUAD:
      begin
        sr_next  = {sr_reg[3:0], io_in[3:0]};
        top_bits = sr_reg[7:4];
      end
      default:
      begin
        // single lane: out on lane 0, in on lane 1
        sr_next  = {sr_reg[6:0], io_in[1]};
        top_bits = {3'b000, sr_reg[7]};
      end
    endcase
  end

  // ---------------------------------------------------------------
  // shift engine
  // ---------------------------------------------------------------
  // data leaves on the falling edge and is sampled on the next rising one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sr_reg    <= 8'h00;
      steps_reg <= 4'h0;
      busy_reg  <= 1'b0;
      armed_reg <= 1'b0;
      io_out    <= 4'h0;
      io_oe     <= 4'h0;
      done      <= 1'b0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      if (start)
      begin
        sr_reg    <= tx_byte;
        busy_reg  <= 1'b1;
        armed_reg <= 1'b0;
        case (lanes)
          LANE_DUAL:
          begin
            steps_reg <= 4'h4;
            io_oe     <= drive ? 4'h3 : 4'h0;
          end
          LANE_QUAD:
          begin
            steps_reg <= 4'h2;
            io_oe     <= drive ? 4'hf : 4'h0;
          end
          default:
          begin
            steps_reg <= 4'h8;
            io_oe     <= 4'h1;
          end
        endcase
      end
      else if (busy_reg && link_fall)
      begin
        io_out    <= top_bits;
        armed_reg <= 1'b1;
      end
      else if (busy_reg && armed_reg && link_rise)
      begin
        sr_reg    <= sr_next;
        steps_reg <= steps_reg - 4'h1;
        armed_reg <= 1'b0;
        if (steps_reg == 4'h1)
        begin
          busy_reg <= 1'b0;
          io_oe    <= 4'h0;
          done     <= 1'b1;
        end
      end
    end
  end

  assign rx_byte = sr_reg;

endmodule : sps_lane_shifter

// ---- verilog/sps_pkg.sv ----
// shared constants and types of the phase sequencer control block
package sps_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_XFER_CTRL = 8'h00;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h04;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h08;
  localparam logic [7:0] OFF_SLOT_BASE = 8'h10;
  localparam logic [7:0] OFF_SLOT_LAST = 8'h2c;
  localparam logic [7:0] SLOT_STRIDE   = 8'h04;

  // ---------------------------------------------------------------
  // transfer_control fields
  // ---------------------------------------------------------------
  localparam int XC_GO_BIT  = 0;
  localparam int XC_DONE_BIT = 2;
  localparam int XC_ERR_BIT = 3;
  localparam int XC_CNT_LSB = 4;
  localparam logic [2:0] XC_CNT_RST = 3'h0;

  // ---------------------------------------------------------------
  // phase_step_control fields
  // ---------------------------------------------------------------
  localparam int SL_ACTIVE_BIT = 0;
  localparam int SL_DONE_BIT   = 1;
  localparam int SL_ERR_BIT    = 2;
  localparam int SL_ACT_LSB    = 4;
  localparam int SL_TOT_LSB    = 8;
  localparam int SL_MODE_LSB   = 20;
  localparam logic [11:0] SL_TOT_RST = 12'h000;

  // ---------------------------------------------------------------
  // interrupt status / mask bits
  // ---------------------------------------------------------------
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT  = 1;
  localparam logic [1:0] IRQ_RST = 2'h0;

  // bytes held by the phase data word before a dma refill is needed
  localparam logic [11:0] DMA_GROUP_BYTES = 12'h004;
  localparam logic [7:0]  DUMMY_BYTE      = 8'hff;

  typedef enum logic [1:0] {
    LANE_SINGLE = 2'h0,
    LANE_DUAL   = 2'h1,
    LANE_QUAD   = 2'h2,
    LANE_BAD    = 2'h3
  } sps_lane_t;

  typedef enum logic [1:0] {
    ACT_TX    = 2'h0,
    ACT_DUMMY = 2'h1,
    ACT_RX    = 2'h2,
    ACT_POLL  = 2'h3
  } sps_act_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_PHASE = 3'h1,
    ST_BYTE  = 3'h2,
    ST_WAIT  = 3'h3,
    ST_POLL  = 3'h4,
    ST_STEP  = 3'h5,
    ST_DRAIN = 3'h6
  } sps_state_t;

endpackage : sps_pkg

// ---- verilog/sps_sequencer.sv ----
// multi-phase serial flash sequencer: apb registers, phase walk, link timing
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module sps_sequencer
  import sps_pkg::*;
#(
  parameter int SLOTS = 8
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        link_clk,
  output logic             flash_cs_n,
  input  wire logic [3:0]  flash_io_in,
  output logic      [3:0]  flash_io_out,
  output logic      [3:0]  flash_io_oe,
  output logic      [1:0]  tx_byte_index,
  input  wire logic [7:0]  tx_byte,
  output logic      [7:0]  rx_byte,
  output logic             rx_valid,
  input  wire logic        poll_pass,
  input  wire logic        poll_fail,
  output logic             dma_req,
  input  wire logic        dma_ack
);
  import sps_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  sps_state_t  state_reg;
  logic [2:0]  step_count_field_reg;
  logic        xfer_done_reg;
  logic        xfer_err_reg;
  logic [1:0]  irq_stat_reg;
  logic [1:0]  irq_mask_reg;
  sps_lane_t   slot_mode_reg [SLOTS];
  logic [11:0] step_byte_total_reg [SLOTS];
  sps_act_t    slot_act_reg [SLOTS];
  logic [SLOTS-1:0] slot_done_reg;
  logic [SLOTS-1:0] slot_err_reg;
  logic [SLOTS-1:0] slot_active_reg;
  logic [2:0]  cur_reg;
  logic [11:0] byte_idx_reg;
  logic [3:0]  dma_pending_reg;
  logic        lclk_s1_reg;
  logic        lclk_s2_reg;
  logic        lclk_s3_reg;
  logic [3:0]  io_s1_reg;
  logic [3:0]  io_s2_reg;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic        access;
  logic        wr_fire;
  logic        slot_hit;
  logic [2:0]  slot_idx;
  logic        go_fire;
  logic        xfer_end;
  logic        err_end;
  logic        link_rise;
  logic        link_fall;
  logic        eng_start;
  logic        eng_done;
  logic [7:0]  eng_rx;
  logic [7:0]  eng_tx;
  sps_lane_t   cur_mode;
  sps_act_t    cur_act;
  logic [11:0] cur_total;
  logic        last_byte;
  logic        group_end;
  logic        dma_use;

  assign access   = psel && penable && !pready;
  // a write lands at the edge where the master sees pready high
  assign wr_fire  = psel && penable && pwrite && pready;
  assign slot_hit = (paddr >= OFF_SLOT_BASE) && (paddr <= OFF_SLOT_LAST) && (paddr[1:0] == 2'b00);
  assign slot_idx = 3'((paddr - OFF_SLOT_BASE) >> 2);
  assign go_fire  = wr_fire && (paddr == OFF_XFER_CTRL) && pwdata[XC_GO_BIT] && (state_reg == ST_IDLE);

  assign cur_mode  = slot_mode_reg[cur_reg];
  assign cur_act   = slot_act_reg[cur_reg];
  assign cur_total = step_byte_total_reg[cur_reg];
  assign last_byte = (byte_idx_reg + 12'h001) >= cur_total;
  assign dma_use   = (cur_total > DMA_GROUP_BYTES) && ((cur_act == ACT_TX) || (cur_act == ACT_RX));
  assign group_end = (byte_idx_reg[1:0] == 2'h3) || last_byte;
  assign eng_tx    = (cur_act == ACT_DUMMY) ? DUMMY_BYTE : tx_byte;
  assign eng_start = (state_reg == ST_BYTE);
  assign xfer_end  = (state_reg == ST_DRAIN) && (dma_pending_reg == 4'h0);
  assign err_end   = xfer_end && (|slot_err_reg);

  // ---------------------------------------------------------------
  // apb read path and handshake
  // ---------------------------------------------------------------
  // one wait state: data is prepared in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (ce)
    begin
      pready  <= access;
      pslverr <= 1'b0;
      if (access)
      begin
        prdata <= 32'h0000_0000;
        if (paddr == OFF_XFER_CTRL)
        begin
          prdata[XC_GO_BIT]                <= (state_reg != ST_IDLE);
          prdata[XC_DONE_BIT]              <= xfer_done_reg;
          prdata[XC_ERR_BIT]               <= xfer_err_reg;
          prdata[XC_CNT_LSB+2:XC_CNT_LSB]  <= step_count_field_reg;
        end
        else if (paddr == OFF_IRQ_STAT)
          prdata[1:0] <= irq_stat_reg;
        else if (paddr == OFF_IRQ_MASK)
          prdata[1:0] <= irq_mask_reg;
        else if (slot_hit)
        begin
          // top byte and unused bits stay zero
          prdata[SL_MODE_LSB+1:SL_MODE_LSB] <= slot_mode_reg[slot_idx];
          prdata[SL_TOT_LSB+11:SL_TOT_LSB]  <= step_byte_total_reg[slot_idx];
          prdata[SL_ACT_LSB+1:SL_ACT_LSB]   <= slot_act_reg[slot_idx];
          prdata[SL_ERR_BIT]                <= slot_err_reg[slot_idx];
          prdata[SL_DONE_BIT]               <= slot_done_reg[slot_idx];
          prdata[SL_ACTIVE_BIT]             <= slot_active_reg[slot_idx];
        end
        else
          pslverr <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // transfer_control
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      step_count_field_reg <= XC_CNT_RST;
    else if (ce && wr_fire && (paddr == OFF_XFER_CTRL) && (state_reg == ST_IDLE))
      step_count_field_reg <= pwdata[XC_CNT_LSB+2:XC_CNT_LSB];
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xfer_done_reg <= 1'b0;
      xfer_err_reg  <= 1'b0;
    end
    else if (ce)
    begin
      if (xfer_end)
      begin
        xfer_done_reg <= 1'b1;
        if (err_end)
          xfer_err_reg <= 1'b1;
      end
      else if (go_fire)
      begin
        xfer_done_reg <= 1'b0;
        xfer_err_reg  <= 1'b0;
      end
      else if (wr_fire && (paddr == OFF_XFER_CTRL))
      begin
        if (!pwdata[XC_DONE_BIT])
          xfer_done_reg <= 1'b0;
        if (!pwdata[XC_ERR_BIT])
          xfer_err_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_reg <= IRQ_RST;
      irq_mask_reg <= IRQ_RST;
      irq          <= 1'b0;
    end
    else if (ce)
    begin
      irq <= |(irq_stat_reg & irq_mask_reg);
      if (wr_fire && (paddr == OFF_IRQ_MASK))
        irq_mask_reg <= pwdata[1:0];
      for (int b = 0; b < 2; b++)
      begin
        if (wr_fire && (paddr == OFF_IRQ_STAT) && pwdata[b])
          irq_stat_reg[b] <= 1'b0;
      end
      if (xfer_end)
        irq_stat_reg[IRQ_DONE_BIT] <= 1'b1;
      if (err_end)
        irq_stat_reg[IRQ_ERR_BIT] <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // phase slots
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int k = 0; k < SLOTS; k++)
      begin
        slot_mode_reg[k]       <= LANE_SINGLE;
        step_byte_total_reg[k] <= SL_TOT_RST;
        slot_act_reg[k]        <= ACT_TX;
      end
    end
    else if (ce && wr_fire && slot_hit)
    begin
      // the forbidden lane code is refused and the old mode kept
      if (pwdata[SL_MODE_LSB+1:SL_MODE_LSB] != LANE_BAD)
        slot_mode_reg[slot_idx] <= sps_lane_t'(pwdata[SL_MODE_LSB+1:SL_MODE_LSB]);
      step_byte_total_reg[slot_idx] <= pwdata[SL_TOT_LSB+11:SL_TOT_LSB];
      slot_act_reg[slot_idx]        <= sps_act_t'(pwdata[SL_ACT_LSB+1:SL_ACT_LSB]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slot_done_reg   <= '0;
      slot_err_reg    <= '0;
      slot_active_reg <= '0;
    end
    else if (ce)
    begin
      if (go_fire)
      begin
        slot_done_reg <= '0;
        slot_err_reg  <= '0;
      end
      else if (state_reg == ST_STEP)
      begin
        slot_done_reg[cur_reg]   <= 1'b1;
        slot_active_reg[cur_reg] <= 1'b0;
      end
      else if (state_reg == ST_PHASE)
        slot_active_reg[cur_reg] <= 1'b1;
      if ((state_reg == ST_POLL) && poll_fail && !poll_pass)
        slot_err_reg[cur_reg] <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // phase walk
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg    <= ST_IDLE;
      cur_reg      <= 3'h0;
      byte_idx_reg <= 12'h000;
      flash_cs_n   <= 1'b1;
    end
    else if (ce)
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (go_fire)
          begin
            cur_reg    <= 3'h0;
            flash_cs_n <= 1'b0;
            state_reg  <= ST_PHASE;
          end
        end
        ST_PHASE:
        begin
          byte_idx_reg <= 12'h000;
          // a poll phase ignores the byte count
          if ((cur_total == 12'h000) && (cur_act != ACT_POLL))
            state_reg <= ST_STEP;
          else
            state_reg <= ST_BYTE;
        end
        ST_BYTE:
          state_reg <= ST_WAIT;
        ST_WAIT:
        begin
          if (eng_done)
          begin
            if (cur_act == ACT_POLL)
              state_reg <= ST_POLL;
            else if (last_byte)
              state_reg <= ST_STEP;
            else
            begin
              byte_idx_reg <= byte_idx_reg + 12'h001;
              state_reg    <= ST_BYTE;
            end
          end
        end
        ST_POLL:
        begin
          if (poll_pass || poll_fail)
            state_reg <= ST_STEP;
          else
            state_reg <= ST_BYTE;
        end
        ST_STEP:
        begin
          if (cur_reg == step_count_field_reg)
          begin
            flash_cs_n <= 1'b1;
            state_reg  <= ST_DRAIN;
          end
          else
          begin
            cur_reg   <= cur_reg + 3'h1;
            state_reg <= ST_PHASE;
          end
        end
        ST_DRAIN:
        begin
          if (dma_pending_reg == 4'h0)
            state_reg <= ST_IDLE;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // data side: byte index, receive strobe, dma requests
  // ---------------------------------------------------------------
  // pending count wraps to zero on the 16th unacknowledged group; a dma that lags further is lost from the count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_byte_index   <= 2'h0;
      rx_byte         <= 8'h00;
      rx_valid        <= 1'b0;
      dma_req         <= 1'b0;
      dma_pending_reg <= 4'h0;
    end
    else if (ce)
    begin
      tx_byte_index <= byte_idx_reg[1:0];
      rx_valid      <= 1'b0;
      dma_req       <= 1'b0;
      if ((state_reg == ST_WAIT) && eng_done && ((cur_act == ACT_RX) || (cur_act == ACT_POLL)))
      begin
        rx_byte  <= eng_rx;
        rx_valid <= 1'b1;
      end
      if ((state_reg == ST_WAIT) && eng_done && dma_use && group_end && !dma_ack)
      begin
        dma_req         <= 1'b1;
        dma_pending_reg <= dma_pending_reg + 4'h1;
      end
      else if ((state_reg == ST_WAIT) && eng_done && dma_use && group_end)
        dma_req <= 1'b1;
      else if (dma_ack && (dma_pending_reg != 4'h0))
        dma_pending_reg <= dma_pending_reg - 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // link clock and pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lclk_s1_reg <= 1'b0;
      lclk_s2_reg <= 1'b0;
      lclk_s3_reg <= 1'b0;
      io_s1_reg   <= 4'h0;
      io_s2_reg   <= 4'h0;
    end
    else if (ce)
    begin
      lclk_s1_reg <= link_clk;
      lclk_s2_reg <= lclk_s1_reg;
      lclk_s3_reg <= lclk_s2_reg;
      io_s1_reg   <= flash_io_in;
      io_s2_reg   <= io_s1_reg;
    end
  end

  assign link_rise = lclk_s2_reg && !lclk_s3_reg;
  assign link_fall = !lclk_s2_reg && lclk_s3_reg;

  sps_lane_shifter u_shift (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .start     (eng_start),
    .tx_byte   (eng_tx),
    .lanes     (cur_mode),
    .drive     ((cur_act == ACT_TX) || (cur_act == ACT_DUMMY)),
    .link_rise (link_rise),
    .link_fall (link_fall),
    .io_in     (io_s2_reg),
    .io_out    (flash_io_out),
    .io_oe     (flash_io_oe),
    .rx_byte   (eng_rx),
    .done      (eng_done)
  );

endmodule : sps_sequencer
